// File: rtl/cis_core_irq.sv
// core interrupt sources, reset-cause register and context save behind an AXI4-Lite slave
`timescale 1ns/100ps
`default_nettype none
module cis_core_irq
  import cis_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic [CIS_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [CIS_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [3:0] ext_irq_pin,
  input wire logic [3:0] port_b_hi_pin,
  input wire logic timer0_tick,
  input wire cis_rst_evt_t rst_evt,
  input wire logic core_sleeping,
  input wire logic core_irq_ack,
  input wire logic core_ack_high,
  input wire logic core_irq_return,
  input wire cis_ctx_t core_ctx,
  output logic irq_high,
  output logic irq_low,
  output logic wake_req,
  output cis_ctx_t ctx_restore,
  output logic soft_brownout_enable
);
  function automatic logic reg_hit(input logic [CIS_AW-1:0] a, input logic [7:0] off);
    reg_hit = (a[7:2] == off[7:2]);
  endfunction

  // bus state
  logic aw_have_r, w_have_r, bvalid_r, rvalid_r;
  logic [CIS_AW-1:0] aw_addr_r;
  logic [31:0] w_data_r, rdata_r;
  logic [3:0] w_strb_r;
  logic [1:0] bresp_r, rresp_r;
  logic wr_en, wr_b0, wr_b1, rd_en;
  logic [31:0] rd_word;
  logic rd_ok;

  // sources and control
  logic [3:0] ext_s1_r, ext_s2_r, ext_prev_r, pb_s1_r, pb_s2_r, pb_prev_r;
  logic [1:0] prime_r;
  logic [3:0] ext_evt;
  logic pb_evt, t0_evt;
  logic [3:0] ext_flag_r, ext_en_r, edge_r;
  logic [2:0] ext_pri_r;
  logic t0_flag_r, t0_en_r, t0_pri_r, pc_flag_r, pc_en_r, pc_pri_r;
  logic gate_r, gate_low_r;
  logic prio_en_r, sbor_r, ri_r, wdt_flag_r, slp_flag_r, por_flag_r, bor_flag_r;
  logic t0_16_r, t0_run_r;
  logic [15:0] t0_cnt_r;
  logic [5:0] pend, pri_vec, en_vec, flag_vec, en_snap_r;
  logic sleep_q_r, irq_high_r, irq_low_r, wake_r;
  logic [20:0] stk_r [0:7];
  logic [3:0] sp_r;
  cis_ctx_t fast_r, ctx_out_r;

  // ---------------- AXI4-Lite slave ----------------
  assign s_axi_awready = !aw_have_r && !bvalid_r;
  assign s_axi_wready = !w_have_r && !bvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign wr_en = ce && aw_have_r && w_have_r && !bvalid_r;
  assign wr_b0 = wr_en && w_strb_r[0];
  assign wr_b1 = wr_en && w_strb_r[1];
  assign rd_en = ce && s_axi_arvalid && !rvalid_r;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= CIS_RESP_OKAY;
      aw_addr_r <= '0;
      w_data_r <= '0;
      w_strb_r <= '0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_en) begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= (aw_addr_r[7:2] <= CIS_OFF_T0CNT[7:2]) ? CIS_RESP_OKAY : CIS_RESP_SLVERR;
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  always_comb begin
    rd_word = '0;
    rd_ok = 1'b1;
    unique case (s_axi_araddr[7:2])
      CIS_OFF_ICR0[7:2]: begin
        rd_word[B_GATE] = gate_r;
        rd_word[B_GATE_LOW] = gate_low_r;
        rd_word[B_T0_EN] = t0_en_r;
        rd_word[B_X0_EN] = ext_en_r[0];
        rd_word[B_PC_EN] = pc_en_r;
        rd_word[B_T0_FLG] = t0_flag_r;
        rd_word[B_X0_FLG] = ext_flag_r[0];
        rd_word[B_PC_FLG] = pc_flag_r;
      end
      CIS_OFF_ICR2[7:2]: begin
        for (int i = 0; i < 4; i++) rd_word[B_EDGE_TOP-i] = edge_r[i];
        rd_word[B_T0_PRI] = t0_pri_r;
        rd_word[B_X3_PRI] = ext_pri_r[2];
        rd_word[B_PC_PRI] = pc_pri_r;
      end
      CIS_OFF_ICR3[7:2]: begin
        rd_word[B_X1_PRI] = ext_pri_r[0];
        rd_word[B_X2_PRI] = ext_pri_r[1];
        for (int i = 1; i < 4; i++) begin
          rd_word[B_X_EN_LSB+i-1] = ext_en_r[i];
          rd_word[B_X_FLG_LSB+i-1] = ext_flag_r[i];
        end
      end
      CIS_OFF_RCC[7:2]: begin
        // bit 5 left at zero: unimplemented
        rd_word[B_PRIO_EN] = prio_en_r;
        rd_word[B_SBOR] = sbor_r;
        rd_word[B_RI] = ri_r;
        rd_word[B_WDT] = wdt_flag_r;
        rd_word[B_SLP] = slp_flag_r;
        rd_word[B_POR] = por_flag_r;
        rd_word[B_BOR] = bor_flag_r;
      end
      CIS_OFF_T0CFG[7:2]: begin
        rd_word[B_T0_16] = t0_16_r;
        rd_word[B_T0_RUN] = t0_run_r;
      end
      CIS_OFF_T0CNT[7:2]: rd_word[15:0] = t0_cnt_r;
      CIS_OFF_CTXPC[7:2]: rd_word = {sp_r, 7'h00, (sp_r != 4'h0) ? stk_r[3'(sp_r - 4'h1)] : 21'h0};
      CIS_OFF_CTXFAST[7:2]: rd_word = {8'h00, fast_r.working_accumulator, fast_r.status, fast_r.bank_select_reg};
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= CIS_RESP_OKAY;
    end else if (ce) begin
      if (rd_en) begin
        rvalid_r <= 1'b1;
        rdata_r <= rd_word;
        rresp_r <= rd_ok ? CIS_RESP_OKAY : CIS_RESP_SLVERR;
      end else if (rvalid_r && s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  // ---------------- pin synchronisers and detectors ----------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ext_s1_r <= '0;
      ext_s2_r <= '0;
      ext_prev_r <= '0;
      pb_s1_r <= '0;
      pb_s2_r <= '0;
      pb_prev_r <= '0;
      prime_r <= '0;
    end else if (ce) begin
      ext_s1_r <= ext_irq_pin;
      ext_s2_r <= ext_s1_r;
      ext_prev_r <= ext_s2_r;
      pb_s1_r <= port_b_hi_pin;
      pb_s2_r <= pb_s1_r;
      pb_prev_r <= pb_s2_r;
      if (prime_r != CIS_PRIME_DONE) prime_r <= prime_r + 2'h1;
    end
  end

  // detectors wait until the pipeline holds real pin samples, so reset is not an edge
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      ext_evt[i] = (prime_r == CIS_PRIME_DONE) && (edge_r[i] ?
        (ext_s2_r[i] && !ext_prev_r[i]) : (!ext_s2_r[i] && ext_prev_r[i]));
    end
  end
  assign pb_evt = (prime_r == CIS_PRIME_DONE) && (pb_s2_r != pb_prev_r);
  assign t0_evt = t0_run_r && timer0_tick &&
    (t0_16_r ? (t0_cnt_r == 16'hFFFF) : (t0_cnt_r[7:0] == 8'hFF));

  // ---------------- flags: event wins over a software clear ----------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ext_flag_r <= '0;
      t0_flag_r <= CIS_ICR0_RST[B_T0_FLG];
      pc_flag_r <= CIS_ICR0_RST[B_PC_FLG];
    end else if (ce) begin
      for (int i = 0; i < 4; i++) begin
        if (i == 0 && wr_b0 && reg_hit(aw_addr_r, CIS_OFF_ICR0))
          ext_flag_r[i] <= w_data_r[B_X0_FLG] || ext_evt[i];
        else if (i != 0 && wr_b0 && reg_hit(aw_addr_r, CIS_OFF_ICR3))
          ext_flag_r[i] <= w_data_r[B_X_FLG_LSB+i-1] || ext_evt[i];
        else if (ext_evt[i])
          ext_flag_r[i] <= 1'b1;
      end
      if (wr_b0 && reg_hit(aw_addr_r, CIS_OFF_ICR0)) begin
        t0_flag_r <= w_data_r[B_T0_FLG] || t0_evt;
        pc_flag_r <= w_data_r[B_PC_FLG] || pb_evt;
      end else begin
        t0_flag_r <= t0_flag_r || t0_evt;
        pc_flag_r <= pc_flag_r || pb_evt;
      end
    end
  end

  // ---------------- enables, priorities, gates ----------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      gate_r <= CIS_ICR0_RST[B_GATE];
      gate_low_r <= CIS_ICR0_RST[B_GATE_LOW];
      t0_en_r <= CIS_ICR0_RST[B_T0_EN];
      pc_en_r <= CIS_ICR0_RST[B_PC_EN];
      ext_en_r <= '0;
      edge_r <= '1;
      t0_pri_r <= CIS_ICR2_RST[B_T0_PRI];
      pc_pri_r <= CIS_ICR2_RST[B_PC_PRI];
      ext_pri_r <= {CIS_ICR2_RST[B_X3_PRI], CIS_ICR3_RST[B_X2_PRI], CIS_ICR3_RST[B_X1_PRI]};
    end else if (ce) begin
      if (wr_b0 && reg_hit(aw_addr_r, CIS_OFF_ICR0)) begin
        gate_r <= w_data_r[B_GATE];
        gate_low_r <= w_data_r[B_GATE_LOW];
        t0_en_r <= w_data_r[B_T0_EN];
        ext_en_r[0] <= w_data_r[B_X0_EN];
        pc_en_r <= w_data_r[B_PC_EN];
      end else if (core_irq_ack) begin
        // entry closes the gate of its level so the handler is not re-entered
        if (core_ack_high || !prio_en_r) gate_r <= 1'b0;
        else gate_low_r <= 1'b0;
      end else if (core_irq_return) begin
        // high level is always left first, so a closed high gate belongs to it
        if (!gate_r) gate_r <= 1'b1;
        else gate_low_r <= 1'b1;
      end
      if (wr_b0 && reg_hit(aw_addr_r, CIS_OFF_ICR2)) begin
        for (int i = 0; i < 4; i++) edge_r[i] <= w_data_r[B_EDGE_TOP-i];
        t0_pri_r <= w_data_r[B_T0_PRI];
        ext_pri_r[2] <= w_data_r[B_X3_PRI];
        pc_pri_r <= w_data_r[B_PC_PRI];
      end
      if (wr_b0 && reg_hit(aw_addr_r, CIS_OFF_ICR3)) begin
        ext_pri_r[0] <= w_data_r[B_X1_PRI];
        ext_pri_r[1] <= w_data_r[B_X2_PRI];
        for (int i = 1; i < 4; i++) ext_en_r[i] <= w_data_r[B_X_EN_LSB+i-1];
      end
    end
  end

  // ---------------- reset-cause register ----------------
  // hardware reset events take precedence over a concurrent software write
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      prio_en_r <= CIS_RCC_RST[B_PRIO_EN];
      sbor_r <= CIS_RCC_RST[B_SBOR];
      ri_r <= CIS_RCC_RST[B_RI];
      wdt_flag_r <= CIS_RCC_RST[B_WDT];
      slp_flag_r <= CIS_RCC_RST[B_SLP];
      por_flag_r <= CIS_RCC_RST[B_POR];
      bor_flag_r <= CIS_RCC_RST[B_BOR];
    end else if (ce) begin
      if (wr_b0 && reg_hit(aw_addr_r, CIS_OFF_RCC)) begin
        prio_en_r <= w_data_r[B_PRIO_EN];
        sbor_r <= w_data_r[B_SBOR];
        ri_r <= w_data_r[B_RI] && !rst_evt.reset_opcode;
        por_flag_r <= w_data_r[B_POR] && !rst_evt.por;
        bor_flag_r <= w_data_r[B_BOR] && !rst_evt.bor;
      end else begin
        if (rst_evt.reset_opcode) ri_r <= 1'b0;
        if (rst_evt.por) por_flag_r <= 1'b0;
        if (rst_evt.bor) bor_flag_r <= 1'b0;
      end
      // read-only flags: the bus never writes them
      if (rst_evt.por || rst_evt.wdt_cleared) begin
        wdt_flag_r <= 1'b1;
        slp_flag_r <= 1'b1;
      end else begin
        if (rst_evt.wdt_expired) wdt_flag_r <= 1'b0;
        if (rst_evt.sleep_cmd) slp_flag_r <= 1'b0;
      end
    end
  end
  assign soft_brownout_enable = sbor_r;

  // ---------------- timer0 counter ----------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      t0_16_r <= CIS_T0CFG_RST[B_T0_16];
      t0_run_r <= CIS_T0CFG_RST[B_T0_RUN];
      t0_cnt_r <= CIS_T0CNT_RST;
    end else if (ce) begin
      if (wr_b0 && reg_hit(aw_addr_r, CIS_OFF_T0CFG)) begin
        t0_16_r <= w_data_r[B_T0_16];
        t0_run_r <= w_data_r[B_T0_RUN];
      end
      if ((wr_b0 || wr_b1) && reg_hit(aw_addr_r, CIS_OFF_T0CNT)) begin
        if (wr_b0) t0_cnt_r[7:0] <= w_data_r[7:0];
        if (wr_b1) t0_cnt_r[15:8] <= w_data_r[15:8];
      end else if (t0_run_r && timer0_tick) begin
        if (t0_16_r) t0_cnt_r <= t0_cnt_r + 16'h0001;
        else t0_cnt_r[7:0] <= t0_cnt_r[7:0] + 8'h01;
      end
    end
  end

  // ---------------- request, priority and wake ----------------
  // vector order: ext0..ext3, timer0, port change
  assign flag_vec = {pc_flag_r, t0_flag_r, ext_flag_r};
  assign en_vec = {pc_en_r, t0_en_r, ext_en_r};
  assign pri_vec = {pc_pri_r, t0_pri_r, ext_pri_r, 1'b1};
  assign pend = flag_vec & en_vec;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      irq_high_r <= 1'b0;
      irq_low_r <= 1'b0;
      wake_r <= 1'b0;
      sleep_q_r <= 1'b0;
      en_snap_r <= '0;
    end else if (ce) begin
      if (prio_en_r) begin
        irq_high_r <= gate_r && |(pend & pri_vec);
        irq_low_r <= gate_r && gate_low_r && |(pend & ~pri_vec);
      end else begin
        irq_high_r <= gate_r && |pend;
        irq_low_r <= 1'b0;
      end
      sleep_q_r <= core_sleeping;
      if (core_sleeping && !sleep_q_r) en_snap_r <= en_vec;
      // wake ignores the gate; only the vector needs it
      wake_r <= core_sleeping && sleep_q_r && |(pend & en_snap_r);
    end
  end
  assign irq_high = irq_high_r;
  assign irq_low = irq_low_r;
  assign wake_req = wake_r;

  // ---------------- context save ----------------
  // a push beyond the depth is dropped; the core must not nest deeper
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sp_r <= 4'h0;
      fast_r <= '0;
      ctx_out_r <= '0;
    end else if (ce) begin
      if (core_irq_ack) begin
        fast_r <= core_ctx;
        if (sp_r < CIS_STK_DEPTH) sp_r <= sp_r + 4'h1;
      end else if (core_irq_return && sp_r != 4'h0) begin
        sp_r <= sp_r - 4'h1;
        ctx_out_r <= '{pc: stk_r[3'(sp_r - 4'h1)], working_accumulator: fast_r.working_accumulator,
                       status: fast_r.status, bank_select_reg: fast_r.bank_select_reg};
      end
    end
  end
  always_ff @(posedge clk_sys) begin
    if (ce && core_irq_ack && sp_r < CIS_STK_DEPTH) stk_r[sp_r[2:0]] <= core_ctx.pc;
  end
  assign ctx_restore = ctx_out_r;

  // ---------------- checks ----------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  a_ext_rise_flag: assert property (ce && ext_evt[1] && edge_r[1] |=> ext_flag_r[1])
    else $error("rising edge did not set pin 1 flag");
  a_edge_polarity: assert property (ce && !edge_r[2] && !ext_flag_r[2] && !wr_en &&
    ext_s2_r[2] && !ext_prev_r[2] |=> !ext_flag_r[2])
    else $error("rising edge flagged while falling selected");
  a_req_needs_pend: assert property (ce && pend == 6'h00 |=> !irq_high && !irq_low)
    else $error("request without enabled pending source");
  a_gate_blocks: assert property (ce && !gate_r |=> !irq_high && !irq_low)
    else $error("vector request with gate closed");
  a_ext0_high: assert property (ce && prio_en_r && gate_r && pend[0] |=> irq_high)
    else $error("pin 0 not raised as high priority");
  a_single_level: assert property (ce && !prio_en_r |=> !irq_low)
    else $error("low level request in single-level mode");
  a_wake_sleep: assert property (ce && core_sleeping && sleep_q_r &&
    |(pend & en_snap_r) |=> wake_req)
    else $error("enabled source failed to wake core");
  a_t0_wrap8: assert property (ce && t0_run_r && !t0_16_r && timer0_tick && !wr_en &&
    t0_cnt_r[7:0] == 8'hFF |=> t0_flag_r && t0_cnt_r[7:0] == 8'h00)
    else $error("8-bit wrap did not set overflow flag");
  a_t0_wrap16: assert property (ce && t0_run_r && t0_16_r && timer0_tick && !wr_en &&
    t0_cnt_r == 16'hFFFF |=> t0_flag_r && t0_cnt_r == 16'h0000)
    else $error("16-bit wrap did not set overflow flag");
  a_port_change: assert property (ce && pb_evt |=> pc_flag_r)
    else $error("port change not flagged");
  a_rcc_bit5: assert property (rd_en && reg_hit(s_axi_araddr, CIS_OFF_RCC)
    |=> s_axi_rvalid && s_axi_rdata[5] == 1'b0)
    else $error("reset-cause bit 5 read as one");
  a_ctx_push: assert property (ce && core_irq_ack && sp_r < CIS_STK_DEPTH
    |=> sp_r == $past(sp_r) + 4'h1 && fast_r == $past(core_ctx))
    else $error("context not saved on entry");
  a_flags_reset: assert property ($fell(sys_rst) |-> wdt_flag_r && slp_flag_r && !prio_en_r)
    else $error("reset-cause flags wrong after reset");

  c_ext_wake: cover property (ce && wake_req ##[1:20] irq_high);
  c_t0_16_wrap: cover property (ce && t0_16_r && t0_evt);
  c_push_pop: cover property (core_irq_ack ##[1:50] core_irq_return);
endmodule // cis_core_irq
`default_nettype wire

// File: rtl/cis_pkg.sv
// package: register map, field positions, reset values and carriers for the core interrupt block
package cis_pkg;
  localparam int unsigned CIS_AW = 8;
  // register byte offsets
  localparam logic [7:0] CIS_OFF_ICR0 = 8'h00;
  localparam logic [7:0] CIS_OFF_ICR2 = 8'h04;
  localparam logic [7:0] CIS_OFF_ICR3 = 8'h08;
  localparam logic [7:0] CIS_OFF_RCC = 8'h0C;
  localparam logic [7:0] CIS_OFF_T0CFG = 8'h10;
  localparam logic [7:0] CIS_OFF_T0CNT = 8'h14;
  localparam logic [7:0] CIS_OFF_CTXPC = 8'h18;
  localparam logic [7:0] CIS_OFF_CTXFAST = 8'h1C;
  // interrupt_control_0 fields
  localparam int unsigned B_GATE = 7;
  localparam int unsigned B_GATE_LOW = 6;
  localparam int unsigned B_T0_EN = 5;
  localparam int unsigned B_X0_EN = 4;
  localparam int unsigned B_PC_EN = 3;
  localparam int unsigned B_T0_FLG = 2;
  localparam int unsigned B_X0_FLG = 1;
  localparam int unsigned B_PC_FLG = 0;
  // interrupt_control_2 fields; edge select of pin i sits at B_EDGE_TOP - i
  localparam int unsigned B_EDGE_TOP = 6;
  localparam int unsigned B_T0_PRI = 2;
  localparam int unsigned B_X3_PRI = 1;
  localparam int unsigned B_PC_PRI = 0;
  // interrupt_control_3 fields; pins 1..3 use LSB + (i - 1)
  localparam int unsigned B_X2_PRI = 7;
  localparam int unsigned B_X1_PRI = 6;
  localparam int unsigned B_X_EN_LSB = 3;
  localparam int unsigned B_X_FLG_LSB = 0;
  // reset_cause_control fields
  localparam int unsigned B_PRIO_EN = 7;
  localparam int unsigned B_SBOR = 6;
  localparam int unsigned B_RI = 4;
  localparam int unsigned B_WDT = 3;
  localparam int unsigned B_SLP = 2;
  localparam int unsigned B_POR = 1;
  localparam int unsigned B_BOR = 0;
  // timer0 config fields
  localparam int unsigned B_T0_16 = 0;
  localparam int unsigned B_T0_RUN = 1;
  // reset values
  localparam logic [7:0] CIS_ICR0_RST = 8'h00;
  localparam logic [7:0] CIS_ICR2_RST = 8'h7F;
  localparam logic [7:0] CIS_ICR3_RST = 8'hC0;
  localparam logic [7:0] CIS_RCC_RST = 8'h5C;
  localparam logic [7:0] CIS_T0CFG_RST = 8'h00;
  localparam logic [15:0] CIS_T0CNT_RST = 16'h0000;
  // bus answers
  localparam logic [1:0] CIS_RESP_OKAY = 2'h0;
  localparam logic [1:0] CIS_RESP_SLVERR = 2'h2;
  // return stack depth and detector priming count
  localparam logic [3:0] CIS_STK_DEPTH = 4'h8;
  localparam logic [1:0] CIS_PRIME_DONE = 2'h3;

  typedef struct packed {
    logic [20:0] pc;
    logic [7:0] working_accumulator;
    logic [7:0] status;
    logic [7:0] bank_select_reg;
  } cis_ctx_t;

  typedef struct packed {
    logic por;
    logic bor;
    logic wdt_expired;
    logic wdt_cleared;
    logic sleep_cmd;
    logic reset_opcode;
  } cis_rst_evt_t;
endpackage

// File: verif/cis_far_model.sv
// far-side model: interrupt pins, port B, timer steps and a core that takes requests
`timescale 1ns/100ps
`default_nettype none
module cis_far_model
  import cis_pkg::*;
(
  input wire logic clk_sys,
  input wire logic irq_high,
  output logic [3:0] ext_irq_pin,
  output logic [3:0] port_b_hi_pin,
  output logic timer0_tick,
  output logic core_sleeping,
  output logic core_irq_ack,
  output logic core_ack_high,
  output logic core_irq_return,
  output cis_ctx_t core_ctx
);
  logic take_r;
  initial begin
    take_r = 1'b0;
    ext_irq_pin = 4'hA;
    port_b_hi_pin = 4'h0;
    timer0_tick = 1'b0;
    core_sleeping = 1'b0;
    core_irq_ack = 1'b0;
    core_ack_high = 1'b0;
    core_irq_return = 1'b0;
    core_ctx = {21'h12345, 8'hA5, 8'h3C, 8'h0F};
  end
  // one entry per arm, so a request that stays up is not taken twice
  always @(posedge clk_sys) begin
    core_irq_ack <= take_r && irq_high;
    core_ack_high <= irq_high;
    if (take_r && irq_high)
      take_r <= 1'b0;
  end
  // non-blocking so the arm never races the ack process at the same edge
  task automatic arm();
    take_r <= 1'b1;
  endtask
  // sleep level changes after an edge; three edges cover snapshot and wake update
  task automatic set_sleep(input logic s);
    @(posedge clk_sys);
    core_sleeping <= s;
    repeat (3) @(posedge clk_sys);
  endtask
  task automatic ret_pulse();
    @(posedge clk_sys);
    core_irq_return <= 1'b1;
    @(posedge clk_sys);
    core_irq_return <= 1'b0;
  endtask
  // pins settle for six cycles: synchroniser plus edge compare
  task automatic set_pins(input logic [3:0] e, input logic [3:0] p);
    @(posedge clk_sys);
    ext_irq_pin <= e;
    port_b_hi_pin <= p;
    repeat (6) @(posedge clk_sys);
  endtask
  task automatic step_timer();
    @(posedge clk_sys);
    timer0_tick <= 1'b1;
    @(posedge clk_sys);
    timer0_tick <= 1'b0;
  endtask
endmodule // cis_far_model
`default_nettype wire

// File: verif/core_interrupt_sources_and_reset_flags_test.sv
// self-checking bench for the core interrupt block over its register bus
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin n_errors++; $display("CHECK FAILED %0t got %h want %h", $time, a, e); end end
module core_interrupt_sources_and_reset_flags_test
  import cis_pkg::*;
;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  // response channels stay ready for the whole run
  logic bready = 1'b1;
  logic arvalid = 1'b0;
  logic rready = 1'b1;
  logic awready, wready, bvalid, arready, rvalid, irq_high, irq_low, sbe, wake;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [3:0] pins, pb;
  logic tick, sleeping, ack, ackh, ret;
  cis_ctx_t ctx;
  cis_ctx_t rctx;
  cis_rst_evt_t evt = '0;
  int n_errors = 0;
  int comparisons = 0;
  always #20 clk_sys = ~clk_sys;
  cis_far_model i_far (.clk_sys(clk_sys), .irq_high(irq_high), .ext_irq_pin(pins),
    .port_b_hi_pin(pb), .timer0_tick(tick), .core_sleeping(sleeping), .core_irq_ack(ack),
    .core_ack_high(ackh), .core_irq_return(ret), .core_ctx(ctx));
  cis_core_irq i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .ce(1'b1), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ext_irq_pin(pins),
    .port_b_hi_pin(pb), .timer0_tick(tick), .rst_evt(evt), .core_sleeping(sleeping),
    .core_irq_ack(ack), .core_ack_high(ackh), .core_irq_return(ret), .core_ctx(ctx),
    .irq_high(irq_high), .irq_low(irq_low), .wake_req(wake), .ctx_restore(rctx),
    .soft_brownout_enable(sbe));
  task automatic close_out();
    if (n_errors == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic guard(inout int n);
    n++;
    if (n > 100) begin
      n_errors++;
      close_out();
    end
  endtask
  // offsets above the timer count answer with an error and change nothing
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (awready === 1'b1)
        awvalid <= 1'b0;
      if (wready === 1'b1)
        wvalid <= 1'b0;
      guard(n);
    end while (bvalid !== 1'b1);
    `CHK(bresp, (a > 8'h14) ? CIS_RESP_SLVERR : CIS_RESP_OKAY)
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (arready === 1'b1)
        arvalid <= 1'b0;
      guard(n);
    end while (rvalid !== 1'b1);
    `CHK(rresp, (a > 8'h1C) ? CIS_RESP_SLVERR : CIS_RESP_OKAY)
    `CHK(rdata & m, e)
  endtask
  initial begin
    repeat (8) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    rchk(CIS_OFF_RCC, 32'hFF, 32'h5C);
    wr(CIS_OFF_RCC, 32'hFF);
    rchk(CIS_OFF_RCC, 32'hFFFFFFFF, 32'hDF);
    `CHK(sbe, 1'b1)
    wr(CIS_OFF_RCC, 32'h00);
    rchk(CIS_OFF_RCC, 32'hFF, 32'h0C);
    `CHK(sbe, 1'b0)
    evt <= 6'h0A; // watchdog expiry and sleep entry
    @(posedge clk_sys);
    evt <= 6'h00;
    rchk(CIS_OFF_RCC, 32'hFF, 32'h00);
    evt <= 6'h20; // power-on event
    @(posedge clk_sys);
    evt <= 6'h00;
    rchk(CIS_OFF_RCC, 32'hFF, 32'h0C);
    rchk(8'h40, 32'h0, 32'h0);
    wr(8'h40, 32'hFF);
    wr(CIS_OFF_ICR2, 32'h28); // pins 1 and 3 rising, 0 and 2 falling
    i_far.set_pins(4'h5, 4'h0);
    rchk(CIS_OFF_ICR0, 32'h02, 32'h00);
    rchk(CIS_OFF_ICR3, 32'h07, 32'h00);
    i_far.set_pins(4'hA, 4'h4);
    rchk(CIS_OFF_ICR0, 32'h03, 32'h03);
    rchk(CIS_OFF_ICR3, 32'h07, 32'h07);
    wr(CIS_OFF_ICR0, 32'h00);
    wr(CIS_OFF_T0CFG, 32'h02);
    wr(CIS_OFF_T0CNT, 32'hFE);
    i_far.step_timer();
    rchk(CIS_OFF_ICR0, 32'h04, 32'h00);
    i_far.step_timer();
    rchk(CIS_OFF_ICR0, 32'h04, 32'h04);
    wr(CIS_OFF_ICR0, 32'h00);
    wr(CIS_OFF_T0CFG, 32'h03);
    wr(CIS_OFF_T0CNT, 32'hFF);
    i_far.step_timer();
    rchk(CIS_OFF_ICR0, 32'h04, 32'h00);
    wr(CIS_OFF_T0CNT, 32'hFFFF);
    i_far.step_timer();
    rchk(CIS_OFF_ICR0, 32'h04, 32'h04);
    wr(CIS_OFF_ICR0, 32'h84); // gate open, every enable off
    repeat (2) @(posedge clk_sys);
    `CHK(irq_high, 1'b0)
    wr(CIS_OFF_ICR0, 32'hA4);
    repeat (2) @(posedge clk_sys);
    `CHK(irq_high, 1'b1)
    `CHK(irq_low, 1'b0)
    i_far.arm();
    repeat (4) @(posedge clk_sys);
    rchk(CIS_OFF_CTXPC, 32'h1FFFFF, 32'h12345);
    rchk(CIS_OFF_CTXFAST, 32'hFFFFFF, 32'hA53C0F);
    rchk(CIS_OFF_ICR0, 32'h80, 32'h00);
    i_far.ret_pulse();
    @(posedge clk_sys);
    `CHK(rctx.pc, 21'h12345)
    `CHK(rctx[23:0], 24'hA53C0F)
    rchk(CIS_OFF_CTXPC, 32'hF0000000, 32'h0);
    wr(CIS_OFF_RCC, 32'h80);
    wr(CIS_OFF_ICR0, 32'hE4);
    repeat (2) @(posedge clk_sys);
    `CHK(irq_low, 1'b1)
    `CHK(irq_high, 1'b0)
    wr(CIS_OFF_ICR2, 32'h2C);
    repeat (2) @(posedge clk_sys);
    `CHK(irq_high, 1'b1)
    wr(CIS_OFF_ICR0, 32'hC4); // timer flag pending, its enable off before sleep
    i_far.set_sleep(1'b1);
    wr(CIS_OFF_ICR0, 32'hE4);
    repeat (2) @(posedge clk_sys);
    `CHK(wake, 1'b0)
    i_far.set_sleep(1'b0);
    i_far.set_sleep(1'b1);
    `CHK(wake, 1'b1)
    wr(CIS_OFF_ICR0, 32'h64);
    repeat (2) @(posedge clk_sys);
    `CHK(wake, 1'b1)
    `CHK(irq_high, 1'b0)
    close_out();
  end
endmodule // core_interrupt_sources_and_reset_flags_test
`default_nettype wire
